// >>> rvt_ring_validation.sv
// ring qualification: period check, confirmation, delay and timeout
//
// Functional notes
// - valid ring shown after delay code (3 bits) times 256 ms.
// - ring ends when code times 128 ms passes after last crossing.
// - ring valid once in tolerance for the selected confirmation time.
// - validation works only while the enable bit is set.
// - each event reloads period timer with assertion field; it decrements.
// - event after period timer expiry means frequency too low.
// - assertion minus max-count sets minimum event spacing, 2 ms steps.
// - remaining timer above max-count field means frequency too high.
module rvt_ring_validation
    import rvt_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_NOM
)
(
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // register port
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    output logic [7:0] rd_data_ff,
    // fields held in the neighbouring register
    input wire logic [1:0] ring_indication_delay_lo,
    input wire logic [5:0] ring_max_count_limit,
    // line side
    input wire logic tip_ring_cross,
    // result
    output logic ring_valid_ff
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [7:0] ctrl_b_ff, ctrl_c_ff, nxt_rd;
    logic ev_meta_ff, ev_sync_ff, ev_prev_ff;
    logic [5:0] per_ff, ras;
    logic [CNT_W-1:0] since_ff, ph_ff, nxt_ph;
    logic [CNT_W-1:0] conf_lim, dly_lim, to_lim;
    rvt_state_t state_ff, nxt_state;
    logic tick, ev, en, seen, wr_b, wr_c;
    logic too_low, too_high, bad, timed_out, conf_done, dly_done;
    logic [2:0] dly_code;
    logic [3:0] to_code;

    // all checks below run on the one clock, quiet in reset
    default clocking dcb @(posedge clock); endclocking
    default disable iff (reset);

    // ------------------------------------------------------------
    // tick prescaler
    // ------------------------------------------------------------
    rvt_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
        .clock(clock),
        .reset(reset),
        .tick_ff(tick)
    );

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    // write strobes per register
    assign wr_b = wr_en && (addr == ADDR_CTRL_B);
    assign wr_c = wr_en && (addr == ADDR_CTRL_C);

    // read mux, unmapped reads as zero
    assign nxt_rd = (addr == ADDR_CTRL_B) ? ctrl_b_ff :
                    (addr == ADDR_CTRL_C) ? ctrl_c_ff : 8'h00;

    // control storage; reserved bit is kept at zero
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            ctrl_b_ff <= CTRL_B_RESET;
            ctrl_c_ff <= CTRL_C_RESET;
            rd_data_ff <= 8'h00;
        end
        else
        begin
            if (wr_b)
                ctrl_b_ff <= wr_data;
            if (wr_c)
                ctrl_c_ff <= wr_data & ~(8'h01 << RSV_BIT);
            if (rd_en)
                rd_data_ff <= nxt_rd;
        end
    end

    // ------------------------------------------------------------
    // field decode and limits in ticks
    // ------------------------------------------------------------
    assign en = ctrl_c_ff[EN_BIT];
    assign ras = ctrl_c_ff[RAS_MSB:RAS_LSB];
    assign dly_code = {ctrl_b_ff[DLY_HI_BIT], ring_indication_delay_lo};
    assign to_code = ctrl_b_ff[TO_MSB:TO_LSB];
    assign conf_lim = rvt_conf_ticks(ctrl_b_ff[CONF_MSB:CONF_LSB]);
    assign dly_lim = CNT_W'(dly_code) * DELAY_STEP_TICKS;
    assign to_lim = CNT_W'(to_code) * TIMEOUT_STEP_TICKS;

    // ------------------------------------------------------------
    // line event synchroniser and edge detect
    // ------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            ev_meta_ff <= 1'b0;
            ev_sync_ff <= 1'b0;
            ev_prev_ff <= 1'b0;
        end
        else
        begin
            ev_meta_ff <= tip_ring_cross;
            ev_sync_ff <= ev_meta_ff;
            ev_prev_ff <= ev_sync_ff;
        end
    end

    assign ev = ev_sync_ff && !ev_prev_ff;

    // ------------------------------------------------------------
    // period check
    // ------------------------------------------------------------
    assign seen = (state_ff != ST_IDLE);
    assign too_low = ev && seen && (per_ff == 6'h00);
    assign too_high = ev && seen && (per_ff > ring_max_count_limit);
    assign bad = (too_low || too_high) && (state_ff != ST_VALID);
    assign timed_out = seen && !ev && (since_ff >= to_lim);

    // period timer and time since last crossing
    always_ff @(posedge clock)
    begin
        if (reset || !en)
        begin
            per_ff <= 6'h00;
            since_ff <= '0;
        end
        else
        begin
            if (ev)
                per_ff <= ras;
            else if (tick && per_ff != 6'h00)
                per_ff <= 6'(per_ff - 6'h01);
            if (ev)
                since_ff <= '0;
            else if (tick && since_ff != '1)
                since_ff <= CNT_W'(since_ff + 1'b1);
        end
    end

    // ------------------------------------------------------------
    // qualification state machine
    // ------------------------------------------------------------
    // confirmation counts only while the period timer runs
    assign conf_done = tick && (per_ff != 6'h00) &&
                       (CNT_W'(ph_ff + 1'b1) >= conf_lim);
    assign dly_done = (ph_ff >= dly_lim);

    always_comb
    begin
        nxt_state = state_ff;
        nxt_ph = ph_ff;
        unique case (state_ff)
            ST_IDLE:
            begin
                nxt_ph = '0;
                if (ev)
                    nxt_state = ST_QUAL;
            end
            ST_QUAL:
            begin
                if (timed_out)
                    nxt_state = ST_IDLE;
                else if (bad)
                    nxt_ph = '0;
                else if (conf_done)
                begin
                    nxt_state = ST_DELAY;
                    nxt_ph = '0;
                end
                else if (tick && per_ff != 6'h00)
                    nxt_ph = CNT_W'(ph_ff + 1'b1);
            end
            ST_DELAY:
            begin
                if (timed_out)
                    nxt_state = ST_IDLE;
                else if (bad)
                begin
                    nxt_state = ST_QUAL;
                    nxt_ph = '0;
                end
                else if (dly_done)
                    nxt_state = ST_VALID;
                else if (tick)
                    nxt_ph = CNT_W'(ph_ff + 1'b1);
            end
            ST_VALID:
            begin
                if (timed_out)
                    nxt_state = ST_IDLE;
            end
        endcase
        if (!en)
        begin
            nxt_state = ST_IDLE;
            nxt_ph = '0;
        end
    end

    // state, phase counter and result flop
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            state_ff <= ST_IDLE;
            ph_ff <= '0;
            ring_valid_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            ph_ff <= nxt_ph;
            ring_valid_ff <= (nxt_state == ST_VALID);
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_disabled_quiet;
        !en |=> !ring_valid_ff && state_ff == ST_IDLE;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet)
        else $error("ring shown while validation disabled");
    property p_reload;
        ev && en |=> per_ff == $past(ras);
    endproperty
    a_reload: assert property (p_reload)
        else $error("period timer not reloaded on event");
    property p_decrement;
        en && !ev && tick && per_ff != 6'h00 ##1 en
        |-> per_ff == 6'($past(per_ff) - 6'h01);
    endproperty
    a_decrement: assert property (p_decrement)
        else $error("period timer did not step down on tick");
    property p_too_low;
        en && state_ff == ST_QUAL && ev && per_ff == 6'h00
        |=> state_ff == ST_QUAL && ph_ff == '0;
    endproperty
    a_too_low: assert property (p_too_low)
        else $error("slow ring not invalidated");
    property p_too_high;
        en && state_ff == ST_DELAY && ev && per_ff > ring_max_count_limit
        |=> state_ff == ST_QUAL && ph_ff == '0;
    endproperty
    a_too_high: assert property (p_too_high)
        else $error("fast ring not invalidated");
    property p_confirm_full;
        state_ff == ST_QUAL ##1 state_ff == ST_DELAY
        |-> CNT_W'($past(ph_ff) + 1'b1) >= $past(conf_lim);
    endproperty
    a_confirm_full: assert property (p_confirm_full)
        else $error("confirmation ended early");
    property p_delay;
        en && state_ff == ST_DELAY && !bad && !timed_out && dly_done
        |=> ring_valid_ff;
    endproperty
    a_delay: assert property (p_delay)
        else $error("valid ring not shown after delay");
    property p_timeout;
        en && timed_out |=> !ring_valid_ff && state_ff == ST_IDLE;
    endproperty
    a_timeout: assert property (p_timeout)
        else $error("ring not ended after timeout");
    property p_reserved_zero;
        wr_c |=> !ctrl_c_ff[RSV_BIT];
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bit stored as one");
    // main scenarios to be reached
    c_valid: cover property ($rose(ring_valid_ff));
    c_too_low: cover property (too_low && state_ff == ST_QUAL);
    c_too_high: cover property (too_high && state_ff == ST_QUAL);
    c_delay_fault: cover property (too_high && state_ff == ST_DELAY);
    c_ring_end: cover property ($fell(ring_valid_ff) && en);

endmodule

// >>> rvt_pkg.sv
// constants and types shared by the ring validation timing block
package rvt_pkg;

    // ------------------------------------------------------------
    // register offsets and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL_B = 8'h17;
    localparam logic [7:0] ADDR_CTRL_C = 8'h18;
    localparam logic [7:0] CTRL_B_RESET = 8'h08;
    localparam logic [7:0] CTRL_C_RESET = 8'h19;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int DLY_HI_BIT = 7;
    localparam int TO_MSB = 6;
    localparam int TO_LSB = 3;
    localparam int CONF_MSB = 2;
    localparam int CONF_LSB = 0;
    localparam int EN_BIT = 7;
    localparam int RSV_BIT = 6;
    localparam int RAS_MSB = 5;
    localparam int RAS_LSB = 0;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLOCK_PERIOD_NS = 10;
    localparam int TICK_MS = 2;
    localparam int TICK_CYCLES_NOM = TICK_MS * 1000000 / CLOCK_PERIOD_NS;
    localparam int DELAY_STEP_MS = 256;
    localparam int TIMEOUT_STEP_MS = 128;
    localparam int CNT_W = 11;
    localparam logic [CNT_W-1:0] DELAY_STEP_TICKS =
        CNT_W'(DELAY_STEP_MS / TICK_MS);
    localparam logic [CNT_W-1:0] TIMEOUT_STEP_TICKS =
        CNT_W'(TIMEOUT_STEP_MS / TICK_MS);
    localparam int CONF_MS [8] = '{100, 150, 200, 256, 384, 512, 640, 1024};

    // ------------------------------------------------------------
    // qualification states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_QUAL,
        ST_DELAY,
        ST_VALID
    } rvt_state_t;

    // confirmation time in ticks for a three-bit code
    function automatic logic [CNT_W-1:0] rvt_conf_ticks(input logic [2:0] code);
        rvt_conf_ticks = CNT_W'(CONF_MS[code] / TICK_MS);
    endfunction

endpackage

// >>> rvt_tick_gen.sv
// prescaler that produces the nominal 2 ms timing tick
module rvt_tick_gen
    import rvt_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_NOM
)
(
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // tick out
    output logic tick_ff
);

    localparam int PW = $clog2(TICK_CYCLES + 1);
    localparam logic [PW-1:0] LAST = PW'(TICK_CYCLES - 1);

    logic [PW-1:0] pre_ff;
    logic wrap;

    // wrap after a full tick period
    assign wrap = (pre_ff == LAST);

    // ------------------------------------------------------------
    // prescale counter
    // ------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            pre_ff <= '0;
            tick_ff <= 1'b0;
        end
        else
        begin
            pre_ff <= wrap ? '0 : PW'(pre_ff + 1'b1);
            tick_ff <= wrap;
        end
    end

endmodule

// >>> rvt_line_model.sv
// behavioural line-side ring threshold detector for the bench
module rvt_line_model
(
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // ringing control from the bench
    input wire logic run,
    input wire logic [15:0] gap,
    // line side crossing events
    output logic tip_ring_cross,
    // time stamps for the bench
    output logic [31:0] cyc,
    output logic [31:0] last_rise
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0] cnt;

    // one crossing every gap cycles while ringing, 3 cycles wide
    // pin stays low between bursts, as a quiet line does
    always @(posedge clock)
    begin
        cyc <= reset ? 32'h0 : cyc + 32'h1;
        if (reset)
        begin
            cnt <= 16'h0000;
            tip_ring_cross <= 1'b0;
            last_rise <= 32'h0;
        end
        else if (run && cnt == 16'h0000)
        begin
            tip_ring_cross <= 1'b1;
            last_rise <= cyc;
            cnt <= gap - 16'h0001;
        end
        else
        begin
            if (cnt != 16'h0000)
                cnt <= cnt - 16'h0001;
            if (gap - cnt >= 16'h0003)
                tip_ring_cross <= 1'b0;
        end
    end
endmodule

// >>> test_rvt_ring_validation.sv
// self-checking bench for the ring validation timing block
module test_rvt_ring_validation import rvt_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    localparam int TC = 10;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wr_data = 8'h00;
    logic [1:0] dly_lo = 2'h0;
    logic [5:0] max_cnt = 6'h0a;
    logic run = 1'b0;
    logic [15:0] gap = 16'h0064;
    logic [7:0] rd_data_ff;
    logic ring_valid_ff;
    logic tip_ring_cross;
    logic [31:0] cyc;
    logic [31:0] last_rise;
    logic [7:0] rv;
    logic [31:0] rnd;
    int mismatches = 0;
    int n_tests = 0;
    int seed = 70026;

    // 100 MHz clock
    always #5 clock = ~clock;

    rvt_ring_validation #(.TICK_CYCLES(TC)) rvt_ring_validation_inst (
        .clock(clock), .reset(reset), .wr_en(wr_en), .rd_en(rd_en),
        .addr(addr), .wr_data(wr_data), .rd_data_ff(rd_data_ff),
        .ring_indication_delay_lo(dly_lo), .ring_max_count_limit(max_cnt),
        .tip_ring_cross(tip_ring_cross), .ring_valid_ff(ring_valid_ff));

    rvt_line_model rvt_line_model_inst (
        .clock(clock), .reset(reset), .run(run), .gap(gap),
        .tip_ring_cross(tip_ring_cross), .cyc(cyc),
        .last_rise(last_rise));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] e,
                       input logic [7:0] g);
        n_tests++;
        if (g !== e)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask

    // timing compare, window of five ticks for tick phase
    task automatic near(input string what, input int e, input int g);
        n_tests++;
        if (g > e + 50 || g + 50 < e)
        begin
            mismatches++;
            $display("Error %s expected %0d seen %0d", what, e, g);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd_en <= 1'b0;
        #1 d = rd_data_ff;
    endtask

    task automatic wait_lvl(input logic lvl, input int lim);
        int i;
        for (i = 0; i < lim && ring_valid_ff !== lvl; i++)
        begin
            @(posedge clock);
            #1;
        end
        if (ring_valid_ff !== lvl)
        begin
            mismatches++;
            $display("Error ring_valid_ff expected %b seen %b", lvl,
                     ring_valid_ff);
            give_verdict();
        end
    endtask

    // faulty or disabled ringing must never be indicated
    task automatic no_ring(input int g, input logic en);
        logic hi = 1'b0;
        reg_wr(ADDR_CTRL_B, 8'h08);
        reg_wr(ADDR_CTRL_C, {en, 7'h14});
        gap <= 16'(g * TC);
        run <= 1'b1;
        repeat (1500)
        begin
            @(posedge clock);
            #1 hi = hi | ring_valid_ff;
        end
        run <= 1'b0;
        chk("ring_valid_ff", 8'h00, {7'h00, hi});
        repeat (800) @(posedge clock);
    endtask

    // ringing turns fast during the delay phase: no ring may follow
    task automatic fast_late();
        int k;
        logic hi = 1'b0;
        reg_wr(ADDR_CTRL_B, 8'h08);
        dly_lo <= 2'h1;
        reg_wr(ADDR_CTRL_C, 8'h94);
        gap <= 16'(15 * TC);
        run <= 1'b1;
        for (k = 0; k < 2300; k++)
        begin
            @(posedge clock);
            if (k == 800)
                gap <= 16'(5 * TC);
            #1 hi = hi | ring_valid_ff;
        end
        run <= 1'b0;
        chk("ring_valid_ff", 8'h00, {7'h00, hi});
        repeat (800) @(posedge clock);
    endtask

    // good ringing: time to indication, then time to ring end
    task automatic ring_case(input logic [2:0] cc, input logic [2:0] dl,
                             input logic [3:0] rt);
        int t0;
        int e;
        reg_wr(ADDR_CTRL_B, {dl[2], rt, cc});
        dly_lo <= dl[1:0];
        reg_wr(ADDR_CTRL_C, 8'h94);
        gap <= 16'(15 * TC);
        run <= 1'b1;
        t0 = int'(cyc);
        e = (CONF_MS[cc] / TICK_MS + dl * DELAY_STEP_MS / TICK_MS) * TC;
        wait_lvl(1'b1, e + 100);
        near("valid delay", e, int'(cyc) - t0);
        run <= 1'b0;
        e = rt * TIMEOUT_STEP_MS / TICK_MS * TC;
        wait_lvl(1'b0, e + 300);
        near("ring end", e, int'(cyc - last_rise));
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (8) @(posedge clock);
        reset <= 1'b0;
        reg_rd(ADDR_CTRL_B, rv);
        chk("ctrl_b reset", CTRL_B_RESET, rv);
        reg_rd(ADDR_CTRL_C, rv);
        chk("ctrl_c reset", 8'h19, rv);
        reg_wr(8'h20, 8'hff);
        reg_rd(8'h20, rv);
        chk("unmapped read", 8'h00, rv);
        reg_wr(ADDR_CTRL_C, 8'hd9);
        reg_rd(ADDR_CTRL_C, rv);
        chk("ctrl_c reserved", 8'h99, rv);
        repeat (4)
        begin
            rnd = $random(seed);
            reg_wr(ADDR_CTRL_B, rnd[7:0] | 8'h08);
            reg_rd(ADDR_CTRL_B, rv);
            chk("ctrl_b rw", rnd[7:0] | 8'h08, rv);
        end
        no_ring(15, 1'b0);
        no_ring(5, 1'b1);
        no_ring(25, 1'b1);
        fast_late();
        ring_case(3'h7, 3'h7, 4'hf);
        ring_case(3'h0, 3'h0, 4'h1);
        repeat (2)
        begin
            rnd = $random(seed);
            @(posedge clock);
            max_cnt <= {3'h0, rnd[2:0]} + 6'h06;
            ring_case(rnd[6:4], rnd[9:7], {2'h0, rnd[11:10]} + 4'h1);
        end
        give_verdict();
    end
endmodule
